// ==== rtl/vfdsc_pkg.sv ====
// shared constants and types for the fluorescent panel scan controller
package vfdsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and pin geometry
  localparam int          APB_AW      = 18;
  localparam int          APB_DW      = 32;
  localparam int          NPINS       = 53;
  localparam int          LAT_HI_W    = NPINS - 32;
  localparam int          DMEM_BYTES  = 48;
  localparam int          DMEM_BANK   = 16;
  localparam int          PAT_W       = 24;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_MODE0      = 16'hFFA0;
  localparam logic [15:0] IDX_MODE1      = 16'hFFA1;
  localparam logic [15:0] IDX_LAT_LO     = 16'hFFA4;
  localparam logic [15:0] IDX_LAT_HI     = 16'hFFA5;
  localparam logic [15:0] IDX_DIR_LO     = 16'hFFA6;
  localparam logic [15:0] IDX_DIR_HI     = 16'hFFA7;
  localparam logic [15:0] IDX_PIN_LO     = 16'hFFA8;
  localparam logic [15:0] IDX_PIN_HI     = 16'hFFA9;
  localparam logic [15:0] IDX_DMEM_FIRST = 16'hFA50;
  localparam logic [15:0] IDX_DMEM_LAST  = 16'hFA7F;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          M0_KSF_BIT  = 7;
  localparam int          M0_NFR_BIT  = 6;
  localparam int          M0_GRID_BIT = 5;
  localparam int          M0_SEG_LSB  = 0;
  localparam int          M0_SEG_W    = 5;
  localparam int          M1_DIG_LSB  = 4;
  localparam int          M1_DIG_W    = 4;
  localparam int          M1_CUT_LSB  = 1;
  localparam int          M1_CUT_W    = 3;
  localparam int          M1_LEN_BIT  = 0;
  localparam logic [7:0]  MODE0_RST   = 8'h00;
  localparam logic [7:0]  MODE1_RST   = 8'h00;
  localparam logic [31:0] LAT_RST     = 32'h0000_0000;
  localparam logic [31:0] DIR_RST     = 32'h0000_0000;
  localparam logic [5:0]  SEG_BASE    = 6'h09;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts in main clock periods
  localparam int          SLOT_SHORT  = 1024;
  localparam int          SLOT_LONG   = 2048;
  localparam int          SLOT_CNT_W  = 11;
  localparam logic [10:0] SLOT_END_S  = 11'(SLOT_SHORT - 1);
  localparam logic [10:0] SLOT_END_L  = 11'(SLOT_LONG - 1);
  localparam logic [2:0]  NF_STABLE_F = 3'h4;
  localparam logic [2:0]  NF_STABLE_S = 3'h2;

  typedef enum logic [1:0] {
    VFDSC_IDLE = 2'b00,
    VFDSC_SCAN = 2'b01,
    VFDSC_KEY  = 2'b11
  } vfdsc_state_t;

endpackage : vfdsc_pkg

// ==== rtl/vfdsc_pin_filter.sv ====
// pin input synchroniser and noise eliminator
`timescale 1ns/1ps
module vfdsc_pin_filter
  import vfdsc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             range_sel,
  input  wire logic [NPINS-1:0] pins_in,
  output logic      [NPINS-1:0] pins_flt
);

  // a slower clock needs fewer samples for the same filter time
  logic [2:0] stable_need;
  assign stable_need = range_sel ? NF_STABLE_S : NF_STABLE_F;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_bit
      logic       s1_r;
      logic       s2_r;
      logic [2:0] cnt_r;
      logic [2:0] cnt_nxt;
      logic       flt_nxt;
      logic       accept;
      assign accept  = (s2_r != pins_flt[g]) && ((cnt_r + 3'h1) >= stable_need);
      assign cnt_nxt = (s2_r == pins_flt[g] || accept) ? 3'h0 : cnt_r + 3'h1;
      assign flt_nxt = accept ? s2_r : pins_flt[g];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r        <= 1'b0;
          s2_r        <= 1'b0;
          cnt_r       <= 3'h0;
          pins_flt[g] <= 1'b0;
        end else begin
          s1_r        <= pins_in[g];
          s2_r        <= s1_r;
          cnt_r       <= cnt_nxt;
          pins_flt[g] <= flt_nxt;
        end
      end
    end
  endgenerate

endmodule : vfdsc_pin_filter

// ==== rtl/vfdsc_top.sv ====
// fluorescent panel scan controller with apb register access
// Operation
// - fetch patterns and strobe digits automatically
// - unused panel pins stay general port pins
// - eight brightness steps via cut width
// - interrupt marks the key-scan slot
// - key-scan slot drives port latches on segments
// - read-only status bit shows key-scan slot
// - basic segment count is field plus nine
// - extended field selects up to forty outputs
// - digits take pins first, segments trimmed
// - mode bit selects free-grid display mode
// - noise filter keeps working during display
// - slot is 1024 or 2048 clocks
// - cut field blanks part of digit pulse
// - digit field zero disables, else plus one
// - disabled scan lets port latches drive pins
// - cycle is digits plus one key slot
// - patterns read from dedicated display memory
// - all digits low during key-scan slot
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module vfdsc_top
  import vfdsc_pkg::*;
(
  input  wire logic                    SYS_CLK,
  input  wire logic                    RESET_N,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [vfdsc_pkg::APB_AW-1:0] PADDR,
  input  wire logic [vfdsc_pkg::APB_DW-1:0] PWDATA,
  input  wire logic [3:0]              PSTRB,
  output logic      [vfdsc_pkg::APB_DW-1:0] PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic [vfdsc_pkg::NPINS-1:0] PANEL_IN,
  output logic      [vfdsc_pkg::NPINS-1:0] PANEL_OUT,
  output logic      [vfdsc_pkg::NPINS-1:0] PANEL_OE,
  output logic                         KEYSCAN_IRQ
);
  import vfdsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // blanked sixteenths: 1, 2, 4 .. 14
  function automatic logic [4:0] cut_sixteenths(input logic [2:0] code);
    return (code == 3'h0) ? 5'h01 : {1'b0, code, 1'b0};
  endfunction : cut_sixteenths

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [6:0]          mode0_r;
  logic [7:0]          mode1_r;
  logic [31:0]         lat_lo_r;
  logic [LAT_HI_W-1:0] lat_hi_r;
  logic [31:0]         dir_lo_r;
  logic [LAT_HI_W-1:0] dir_hi_r;
  logic [7:0]          dmem_r [0:DMEM_BYTES-1];
  vfdsc_state_t        state_r;
  vfdsc_state_t        state_nxt;
  logic [10:0]         cnt_r;
  logic [10:0]         cnt_nxt;
  logic [3:0]          slot_r;
  logic [3:0]          slot_nxt;
  logic [PAT_W-1:0]    pat_r;
  logic [PAT_W-1:0]    pat_nxt;
  logic                pready_r;
  logic                irq_nxt;
  logic [NPINS-1:0]    pin_out_nxt;
  logic [NPINS-1:0]    pin_oe_nxt;
  logic [NPINS-1:0]    pins_flt;

  ////////////////////////////////////////////////////////////////////////////
  // mode field decode
  wire logic [4:0] seg_field = mode0_r[M0_SEG_LSB +: M0_SEG_W];
  wire logic       grid_mode = mode0_r[M0_GRID_BIT];
  wire logic       nf_range  = mode0_r[M0_NFR_BIT];
  wire logic [3:0] dig_field = mode1_r[M1_DIG_LSB +: M1_DIG_W];
  wire logic [2:0] cut_field = mode1_r[M1_CUT_LSB +: M1_CUT_W];
  wire logic       long_slot = mode1_r[M1_LEN_BIT];
  wire logic       scan_en   = (dig_field != 4'h0);
  wire logic [3:0] last_dig  = dig_field;
  wire logic [5:0] nseg      = {1'b0, seg_field} + SEG_BASE;
  wire logic [5:0] grid_base = (grid_mode || !scan_en) ? 6'h00 : {2'b00, dig_field} + 6'h01;
  wire logic [5:0] pins_left = 6'(NPINS) - grid_base;
  wire logic [5:0] nseg_eff  = !scan_en ? 6'h00 : ((nseg > pins_left) ? pins_left : nseg);
  wire logic [5:0] seg_end   = grid_base + nseg_eff;

  ////////////////////////////////////////////////////////////////////////////
  // slot timing
  // slot length
  wire logic [10:0] slot_end = long_slot ? SLOT_END_L : SLOT_END_S;
  wire logic        slot_done = (cnt_r >= slot_end);
  wire logic [3:0]  pos16    = long_slot ? cnt_r[10:7] : cnt_r[9:6];
  // pulse cut blanks the slot head
  wire logic        pulse_on = ({1'b0, pos16} >= cut_sixteenths(cut_field));
  wire logic        key_slot = (state_r == VFDSC_KEY);

  always_comb begin
    state_nxt = state_r;
    slot_nxt  = slot_r;
    cnt_nxt   = slot_done ? 11'h000 : cnt_r + 11'h001;
    irq_nxt   = 1'b0;
    case (state_r)
      VFDSC_IDLE: begin
        cnt_nxt = 11'h000;
        if (scan_en) begin
          state_nxt = VFDSC_SCAN;
          slot_nxt  = 4'h0;
        end
      end
      VFDSC_SCAN: begin
        if (slot_done && slot_r >= last_dig) begin
          state_nxt = VFDSC_KEY;
          irq_nxt   = 1'b1;
        end else if (slot_done) begin
          slot_nxt = slot_r + 4'h1;
        end
      end
      VFDSC_KEY: begin
        if (slot_done) begin
          state_nxt = VFDSC_SCAN;
          slot_nxt  = 4'h0;
        end
      end
      default: begin
        state_nxt = VFDSC_IDLE;
        slot_nxt  = 4'h0;
      end
    endcase
    if (!scan_en) begin
      state_nxt = VFDSC_IDLE;
      slot_nxt  = 4'h0;
      irq_nxt   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display memory fetch
  // pattern latched as each slot opens
  wire logic       slot_load = (state_nxt == VFDSC_SCAN) &&
                               (state_r != VFDSC_SCAN || slot_nxt != slot_r);
  assign pat_nxt = slot_load ? {dmem_r[2*DMEM_BANK + int'(slot_nxt)],
                                dmem_r[DMEM_BANK + int'(slot_nxt)],
                                dmem_r[int'(slot_nxt)]} : pat_r;

  ////////////////////////////////////////////////////////////////////////////
  // panel pin assignment
  wire logic [NPINS-1:0] lat_all = {lat_hi_r, lat_lo_r};
  wire logic [NPINS-1:0] dir_all = {dir_hi_r, dir_lo_r};

  genvar p;
  generate
    for (p = 0; p < NPINS; p++) begin : g_pin
      wire logic [5:0] pidx   = 6'(p);
      wire logic       is_dig = (pidx < grid_base);
      wire logic       is_seg = (pidx >= grid_base) && (pidx < seg_end);
      wire logic [5:0] sidx   = pidx - grid_base;
      wire logic       pbit   = (sidx < 6'(PAT_W)) ? pat_r[sidx[4:0]] : 1'b0;
      // one strobe per slot; digits low in key slot
      wire logic       dig_v  = (state_r == VFDSC_SCAN) && (slot_r == pidx[3:0]) && pulse_on;
      wire logic       seg_v  = key_slot ? lat_all[p] : (pbit && pulse_on);
      assign pin_out_nxt[p] = is_dig ? dig_v : (is_seg ? seg_v : lat_all[p]);
      assign pin_oe_nxt[p]  = (is_dig || is_seg) ? 1'b1 : dir_all[p];
    end
  endgenerate

  // filter runs regardless of scan state
  vfdsc_pin_filter u_filter (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .range_sel(nf_range),
    .pins_in  (PANEL_IN),
    .pins_flt (pins_flt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic [15:0] idx      = PADDR[APB_AW-1:2];
  wire logic        aligned  = (PADDR[1:0] == 2'b00);
  wire logic        sel_m0   = aligned && (idx == IDX_MODE0);
  wire logic        sel_m1   = aligned && (idx == IDX_MODE1);
  wire logic        sel_lalo = aligned && (idx == IDX_LAT_LO);
  wire logic        sel_lahi = aligned && (idx == IDX_LAT_HI);
  wire logic        sel_dilo = aligned && (idx == IDX_DIR_LO);
  wire logic        sel_dihi = aligned && (idx == IDX_DIR_HI);
  wire logic        sel_pilo = aligned && (idx == IDX_PIN_LO);
  wire logic        sel_pihi = aligned && (idx == IDX_PIN_HI);
  wire logic        sel_dmem = aligned && (idx >= IDX_DMEM_FIRST) && (idx <= IDX_DMEM_LAST);
  wire logic        mapped   = sel_m0 || sel_m1 || sel_lalo || sel_lahi || sel_dilo ||
                               sel_dihi || sel_pilo || sel_pihi || sel_dmem;
  wire logic [15:0] dm_off16 = idx - IDX_DMEM_FIRST;
  wire logic [5:0]  dm_off   = dm_off16[5:0];
  wire logic        setup    = PSEL && !PENABLE;
  // write lands on the access edge where pready is seen high
  wire logic        wr_go    = PSEL && PENABLE && pready_r && PWRITE && mapped;

  wire logic [7:0]  mode0_rd = {key_slot, mode0_r};
  wire logic [31:0] rd_val   =
    sel_m0   ? {24'h000000, mode0_rd} :
    sel_m1   ? {24'h000000, mode1_r} :
    sel_lalo ? lat_lo_r :
    sel_lahi ? {{(32-LAT_HI_W){1'b0}}, lat_hi_r} :
    sel_dilo ? dir_lo_r :
    sel_dihi ? {{(32-LAT_HI_W){1'b0}}, dir_hi_r} :
    sel_pilo ? pins_flt[31:0] :
    sel_pihi ? {{(32-LAT_HI_W){1'b0}}, pins_flt[NPINS-1:32]} :
    sel_dmem ? {24'h000000, dmem_r[dm_off]} : 32'h0000_0000;

  wire logic [31:0] m0_w   = apply_strb({25'h0000000, mode0_r}, PWDATA, PSTRB);
  wire logic [31:0] m1_w   = apply_strb({24'h000000, mode1_r}, PWDATA, PSTRB);
  wire logic [31:0] lalo_w = apply_strb(lat_lo_r, PWDATA, PSTRB);
  wire logic [31:0] lahi_w = apply_strb({{(32-LAT_HI_W){1'b0}}, lat_hi_r}, PWDATA, PSTRB);
  wire logic [31:0] dilo_w = apply_strb(dir_lo_r, PWDATA, PSTRB);
  wire logic [31:0] dihi_w = apply_strb({{(32-LAT_HI_W){1'b0}}, dir_hi_r}, PWDATA, PSTRB);

  ////////////////////////////////////////////////////////////////////////////
  // apb registers
  // zero-wait slave: data and error are prepared in the setup cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_r <= 1'b0;
      PRDATA   <= 32'h0000_0000;
      PSLVERR  <= 1'b0;
    end else begin
      pready_r <= setup;
      PRDATA   <= (setup && !PWRITE) ? rd_val : 32'h0000_0000;
      PSLVERR  <= setup && !mapped;
    end
  end
  assign PREADY = pready_r;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode0_r  <= MODE0_RST[6:0];
      mode1_r  <= MODE1_RST;
      lat_lo_r <= LAT_RST;
      lat_hi_r <= LAT_RST[LAT_HI_W-1:0];
      dir_lo_r <= DIR_RST;
      dir_hi_r <= DIR_RST[LAT_HI_W-1:0];
    end else if (wr_go) begin
      if (sel_m0)   mode0_r  <= m0_w[6:0];
      if (sel_m1)   mode1_r  <= m1_w[7:0];
      if (sel_lalo) lat_lo_r <= lalo_w;
      if (sel_lahi) lat_hi_r <= lahi_w[LAT_HI_W-1:0];
      if (sel_dilo) dir_lo_r <= dilo_w;
      if (sel_dihi) dir_hi_r <= dihi_w[LAT_HI_W-1:0];
    end
  end

  // unused memory bytes act as plain ram; contents undefined after power-up
  always_ff @(posedge SYS_CLK) begin
    if (wr_go && sel_dmem && PSTRB[0]) begin
      dmem_r[dm_off] <= PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer and pin registers
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r     <= VFDSC_IDLE;
      cnt_r       <= 11'h000;
      slot_r      <= 4'h0;
      pat_r       <= 24'h000000;
      KEYSCAN_IRQ <= 1'b0;
      PANEL_OUT   <= '0;
      PANEL_OE    <= '0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      slot_r      <= slot_nxt;
      pat_r       <= pat_nxt;
      KEYSCAN_IRQ <= irq_nxt;
      PANEL_OUT   <= pin_out_nxt;
      PANEL_OE    <= pin_oe_nxt;
    end
  end

endmodule : vfdsc_top

// ==== testbench/vfdsc_scan_asserts.sv ====
// port-level assertions for the panel scan controller
`timescale 1ns/1ps
module vfdsc_scan_asserts
  import vfdsc_pkg::*;
(
  input wire logic                         SYS_CLK,
  input wire logic                         RESET_N,
  input wire logic                         PSEL,
  input wire logic                         PENABLE,
  input wire logic                         PWRITE,
  input wire logic [vfdsc_pkg::APB_AW-1:0] PADDR,
  input wire logic [vfdsc_pkg::APB_DW-1:0] PWDATA,
  input wire logic                         PREADY,
  input wire logic                         PSLVERR,
  input wire logic [vfdsc_pkg::NPINS-1:0]  PANEL_OUT,
  input wire logic [vfdsc_pkg::NPINS-1:0]  PANEL_OE,
  input wire logic                         KEYSCAN_IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of mode1 and the latch registers, seen from bus writes
  wire         wr_ok  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  wire         wr_m1  = wr_ok && (PADDR == {IDX_MODE1, 2'b00});
  logic [7:0]  m1_r;
  logic [52:0] lat_r;
  logic [15:0] cnt_r;
  logic        seen_r;
  wire  [3:0]  dig    = m1_r[7:4];
  wire  [5:0]  segp   = {2'b00, dig} + 6'h01;
  wire  [15:0] slot   = m1_r[0] ? 16'h0800 : 16'h0400;
  wire  [15:0] cutn   = (m1_r[3:1] == 3'h0) ? 16'h0001 : {12'h000, m1_r[3:1], 1'b0};
  wire  [15:0] blank  = cutn * (slot >> 4);
  wire  [15:0] period = ({12'h000, dig} + 16'h0002) * slot;

  // a mode1 write voids the running cycle measurement
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      m1_r   <= 8'h00;
      lat_r  <= '0;
      cnt_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      cnt_r  <= KEYSCAN_IRQ ? 16'h0001 : cnt_r + 16'h0001;
      seen_r <= (seen_r | KEYSCAN_IRQ) & ~wr_m1;
      if (wr_m1) m1_r <= PWDATA[7:0];
      if (wr_ok && PADDR == {IDX_LAT_LO, 2'b00}) lat_r[31:0] <= PWDATA;
      if (wr_ok && PADDR == {IDX_LAT_HI, 2'b00}) lat_r[52:32] <= PWDATA[20:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  property p_irq_pulse; KEYSCAN_IRQ |=> !KEYSCAN_IRQ [*8]; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a single pulse");
  property p_period; KEYSCAN_IRQ && seen_r |-> cnt_r == period; endproperty
  a_period: assert property (p_period) else $error("display cycle length wrong");
  property p_blank; seen_r && dig != 0 && cnt_r > slot + 2 && cnt_r < slot + blank - 2
    |-> !PANEL_OUT[0]; endproperty
  a_blank: assert property (p_blank) else $error("digit lit inside cut width");
  property p_lit; seen_r && dig != 0 && cnt_r > slot + blank + 2 && cnt_r < 2 * slot - 2
    |-> PANEL_OUT[0]; endproperty
  a_lit: assert property (p_lit) else $error("digit dark after cut width");
  property p_key_dig; KEYSCAN_IRQ |-> ##2 (!PANEL_OUT[0] && !PANEL_OUT[dig]) [*6]; endproperty
  a_key_dig: assert property (p_key_dig) else $error("digit high in key slot");
  property p_key_seg; KEYSCAN_IRQ |-> ##2 (PANEL_OUT[segp] == lat_r[segp]) [*6]; endproperty
  a_key_seg: assert property (p_key_seg) else $error("key slot segment not latch");
  property p_static; dig == 0 && $past(dig) == 0 && $stable(lat_r) |-> PANEL_OUT == lat_r;
  endproperty
  a_static: assert property (p_static) else $error("static pins differ from latch");
  property p_no_irq; dig == 0 && $past(dig) == 0 |-> !KEYSCAN_IRQ; endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while scan disabled");
  property p_reset; $rose(RESET_N) |-> PANEL_OE == '0 && !KEYSCAN_IRQ; endproperty
  a_reset: assert property (p_reset) else $error("pins active after reset");
endmodule : vfdsc_scan_asserts

bind vfdsc_top vfdsc_scan_asserts vfdsc_scan_asserts_inst (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PANEL_OUT(PANEL_OUT), .PANEL_OE(PANEL_OE), .KEYSCAN_IRQ(KEYSCAN_IRQ)
);

// ==== testbench/vfdsc_panel_model.sv ====
// behavioural panel with pull-downs and a single key of the matrix
`timescale 1ns/1ps
module vfdsc_panel_model
  import vfdsc_pkg::*;
#(
  parameter int SCAN_PIN = 2,
  parameter int RET_PIN  = 40
)
(
  input  wire logic [vfdsc_pkg::NPINS-1:0] pin_out,
  input  wire logic [vfdsc_pkg::NPINS-1:0] pin_oe,
  input  wire logic                        key_down,
  output logic      [vfdsc_pkg::NPINS-1:0] pin_lvl
);
  // released pins fall low through the panel pull-downs, never hold a stale value
  always_comb begin
    pin_lvl = pin_out & pin_oe;
    if (!pin_oe[RET_PIN])
      pin_lvl[RET_PIN] = key_down & pin_oe[SCAN_PIN] & pin_out[SCAN_PIN];
  end
endmodule : vfdsc_panel_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the panel scan controller
`timescale 1ns/1ps
module tb_top
  import vfdsc_pkg::*;
;
  logic             SYS_CLK = 1'b0;
  logic             RESET_N = 1'b0;
  logic             PSEL    = 1'b0;
  logic             PENABLE = 1'b0;
  logic             PWRITE  = 1'b0;
  logic [17:0]      PADDR   = '0;
  logic [31:0]      PWDATA  = '0;
  logic [31:0]      PRDATA;
  logic             PREADY, PSLVERR, KEYSCAN_IRQ;
  logic [NPINS-1:0] PANEL_IN, PANEL_OUT, PANEL_OE;
  logic             key_down = 1'b0;
  int               mismatches = 0;
  int               num_checks = 0;
  int               nirq;

  // one main clock times the whole panel
  always #20 SYS_CLK = ~SYS_CLK;

  vfdsc_top vfdsc_top_inst (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PANEL_IN(PANEL_IN), .PANEL_OUT(PANEL_OUT), .PANEL_OE(PANEL_OE),
    .KEYSCAN_IRQ(KEYSCAN_IRQ)
  );
  vfdsc_panel_model vfdsc_panel_model_inst (
    .pin_out(PANEL_OUT), .pin_oe(PANEL_OE), .key_down(key_down), .pin_lvl(PANEL_IN)
  );

  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  task automatic chk(input logic [52:0] got, input logic [52:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    int k;
    k = 0;
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    chk(53'(k < 16), 53'h1);
    chk(53'(PSLVERR), 53'(xe));
    if (!w) chk(53'(PRDATA), 53'(xd));
  endtask : acc

  // set mode1, then time one whole display cycle and the lit part of digit 0
  task automatic measure(input logic [7:0] m1);
    int n;
    int hi;
    int slot;
    int cutn;
    n    = 0;
    hi   = 0;
    slot = m1[0] ? 2048 : 1024;
    cutn = (m1[3:1] == 3'h0) ? 1 : 2 * m1[3:1];
    acc(1'b1, ba(IDX_MODE1), {24'h0, m1}, '0, 1'b0);
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (KEYSCAN_IRQ !== 1'b1 && n < 40000);
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
      hi += (PANEL_OUT[0] === 1'b1);
    end while (KEYSCAN_IRQ !== 1'b1 && n < 40000);
    chk(53'(n), 53'((m1[7:4] + 2) * slot));
    chk(53'(hi), 53'(slot - cutn * slot / 16));
  endtask : measure

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    repeat (3) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    acc(1'b0, ba(IDX_MODE0), '0, 32'h0, 1'b0);
    acc(1'b0, ba(IDX_MODE1), '0, 32'h0, 1'b0);
    acc(1'b0, ba(16'h1234), '0, 32'h0, 1'b1);
    acc(1'b0, ba(IDX_MODE0) | 18'h1, '0, 32'h0, 1'b1);
    acc(1'b1, ba(IDX_LAT_LO), 32'h0000_0554, '0, 1'b0);
    acc(1'b1, ba(IDX_LAT_HI), 32'h0010_0001, '0, 1'b0);
    acc(1'b1, ba(IDX_DIR_LO), 32'h0000_0FFF, '0, 1'b0);
    acc(1'b1, ba(IDX_DIR_HI), 32'h0010_0000, '0, 1'b0);
    key_down <= 1'b1;
    repeat (16) @(posedge SYS_CLK);
    chk(PANEL_OUT, 53'h10_0001_0000_0554);
    chk(PANEL_OE, 53'h10_0000_0000_0FFF);
    acc(1'b0, ba(IDX_PIN_LO), '0, 32'h0000_0554, 1'b0);
    acc(1'b0, ba(IDX_PIN_HI), '0, 32'h0010_0100, 1'b0);
    acc(1'b1, ba(IDX_PIN_LO), 32'hFFFF_FFFF, '0, 1'b0);
    acc(1'b0, ba(IDX_PIN_LO), '0, 32'h0000_0554, 1'b0);
    acc(1'b1, ba(IDX_DMEM_FIRST), 32'h0000_00A5, '0, 1'b0);
    acc(1'b1, ba(16'hFA60), 32'h0000_0001, '0, 1'b0);
    acc(1'b1, ba(IDX_DMEM_LAST), 32'h0000_005E, '0, 1'b0);
    acc(1'b0, ba(IDX_DMEM_LAST), '0, 32'h0000_005E, 1'b0);
    acc(1'b1, ba(IDX_MODE0), 32'h0000_00C0, '0, 1'b0);
    acc(1'b0, ba(IDX_MODE0), '0, 32'h0000_0040, 1'b0);
    // every cut code with two digits, then long slot and eight digits
    for (int c = 0; c < 8; c++) begin
      measure({4'h1, 3'(c), 1'b0});
      if (c == 0) begin
        acc(1'b0, ba(IDX_MODE0), '0, 32'h0000_00C0, 1'b0);
        chk(53'(PANEL_OUT[10:0]), 53'h554);
        repeat (1100) @(posedge SYS_CLK);
        chk(53'(PANEL_OUT[10:0]), 53'h695);
        acc(1'b0, ba(IDX_MODE0), '0, 32'h0000_0040, 1'b0);
      end
    end
    measure(8'h11);
    measure(8'h70);
    // pin split: segment field, trimming, then free-grid mode
    acc(1'b1, ba(IDX_MODE0), 32'h0000_004F, '0, 1'b0);
    repeat (2) @(posedge SYS_CLK);
    chk(PANEL_OE, 53'h10_0000_FFFF_FFFF);
    acc(1'b1, ba(IDX_MODE0), 32'h0000_005F, '0, 1'b0);
    repeat (2) @(posedge SYS_CLK);
    chk(PANEL_OE, 53'h10_FFFF_FFFF_FFFF);
    acc(1'b1, ba(IDX_MODE1), 32'h0000_00F0, '0, 1'b0);
    repeat (2) @(posedge SYS_CLK);
    chk(PANEL_OE, 53'h1F_FFFF_FFFF_FFFF);
    acc(1'b1, ba(IDX_MODE0), 32'h0000_006F, '0, 1'b0);
    repeat (2) @(posedge SYS_CLK);
    chk(PANEL_OE, 53'h10_0000_00FF_FFFF);
    acc(1'b1, ba(IDX_MODE1), '0, '0, 1'b0);
    repeat (3) @(posedge SYS_CLK);
    chk(PANEL_OUT, 53'h10_0001_0000_0554);
    nirq = 0;
    repeat (3100) begin
      @(posedge SYS_CLK);
      nirq += KEYSCAN_IRQ;
    end
    chk(53'(nirq), 53'h0);
    RESET_N <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    chk(PANEL_OE, '0);
    acc(1'b0, ba(IDX_LAT_LO), '0, 32'h0, 1'b0);
    acc(1'b0, ba(IDX_MODE0), '0, 32'h0, 1'b0);
    test_done();
  end

  initial begin
    repeat (95000) @(posedge SYS_CLK);
    mismatches++;
    test_done();
  end
endmodule : tb_top
